// *** bench/psld_core_sva.sv ***
/* port checker for the dimming core.
   assumes it is bound onto every core instance. */
`timescale 1ns/10ps
module psld_core_sva #(parameter int NSTR = 8) (
  input wire logic i_core_clk, // clk
  input wire logic i_nrst, // rst
  input wire logic i_pwm, // pwm
  input wire logic i_sync, // ref
  input wire logic i_two_input, // mode
  input wire logic i_stagger_off, // flat
  input wire logic [NSTR-1:0] i_str_en, // en
  input wire psld_pkg::psld_ovr_t i_ovr, // ovr
  input wire logic [NSTR-1:0] o_dim, // dim
  input wire logic [psld_pkg::CW-1:0] o_period, // per
  input wire logic [psld_pkg::CW-1:0] o_duty // duty
);
  // ****
  // edge history and assertions
  // ****
  logic [3:0] pw_r, sy_r;
  // three cycles of history cover the registered update slack
  always_ff @(posedge i_core_clk)
    {pw_r, sy_r} <= {pw_r[2:0], i_pwm, sy_r[2:0], i_sync};
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  a_quiet_after_reset: assert property ($rose(i_nrst) |-> o_dim == '0 && o_period == '0)
    else $error("outputs busy after reset");
  a_disabled_dark: assert property ((o_dim & ~i_str_en & ~$past(i_str_en)) == '0)
    else $error("disabled string driven");
  a_rise_needs_en: assert property ((o_dim & ~$past(o_dim) & ~$past(i_str_en)) == '0)
    else $error("string rose while disabled");
  a_none_enabled: assert property (i_str_en == '0 && $past(i_str_en) == '0 |-> o_dim == '0)
    else $error("output with no string enabled");
  a_duty_on_pwm: assert property ($changed(o_duty) && !i_ovr.duty_ovr && !i_two_input
    |-> |(pw_r[2:0] & ~pw_r[3:1])) else $error("duty moved without pwm edge");
  a_period_on_pwm: assert property ($changed(o_period) && !i_ovr.freq_ovr && !i_two_input
    |-> |(pw_r[2:0] & ~pw_r[3:1])) else $error("period moved without pwm edge");
  a_period_on_ref: assert property ($changed(o_period) && !i_ovr.freq_ovr && i_two_input
    |-> |(sy_r[2:0] & ~sy_r[3:1])) else $error("period moved without ref edge");
  a_flat_aligned: assert property (i_stagger_off && $past(i_stagger_off, 2)
    && i_str_en == $past(i_str_en, 2) |-> o_dim == '0 || o_dim == i_str_en)
    else $error("strings not aligned");
  c_string_rise: cover property ($rose(o_dim[0]));
  c_ref_period: cover property (i_two_input && $changed(o_period));
  c_flat_on: cover property (i_stagger_off && o_dim == i_str_en && o_dim != '0);
endmodule : psld_core_sva
bind psld_core psld_core_sva #(.NSTR(NSTR)) psld_core_sva_i (.i_core_clk(i_core_clk),
  .i_nrst(i_nrst), .i_pwm(i_pwm), .i_sync(i_sync), .i_two_input(i_two_input),
  .i_stagger_off(i_stagger_off), .i_str_en(i_str_en), .i_ovr(i_ovr), .o_dim(o_dim),
  .o_period(o_period), .o_duty(o_duty));

// *** bench/psld_src.sv ***
/* pulse source standing in for the host pwm or ref pin.
   assumes period and high time in core cycles. */
`timescale 1ns/10ps
module psld_src (
  input wire logic i_clk, // clock
  input wire logic [23:0] i_per, // period
  input wire logic [23:0] i_hi, // high time
  output logic o_wave // pin
);
  int cnt = 0;
  initial o_wave = 1'b0;
  // falling edge keeps the pin away from the sampling edge
  always @(negedge i_clk)
  begin
    cnt = (cnt + 1 >= int'(i_per)) ? 0 : cnt + 1;
    o_wave <= cnt < int'(i_hi);
  end
endmodule : psld_src

// *** bench/test_phase_shifted_led_dimming.sv ***
/* self-checking bench: a table of modes against a counting model.
   assumes psld_src drives the pins. */
`timescale 1ns/10ps
module test_phase_shifted_led_dimming;
  logic clk = 1'b0, nrst = 1'b0, two = 1'b0, flat = 1'b0, pwm, sync;
  logic [7:0] en = 8'hff, dim;
  logic [23:0] pp = 24'h0003e8, ph = 24'h000190, ps = 24'h0004e2, per, dut;
  psld_pkg::psld_ovr_t ovr = {2'h0, 24'h0004b0, 24'h000190};
  int failures = 0, checks = 0, cyc = 0;
  always #10 clk = ~clk;
  psld_src psld_src_i (.i_clk(clk), .i_per(pp), .i_hi(ph), .o_wave(pwm));
  psld_src psld_src_ref_i (.i_clk(clk), .i_per(ps), .i_hi(24'h000001), .o_wave(sync));
  psld_core psld_core_i (.i_core_clk(clk), .i_nrst(nrst), .i_pwm(pwm), .i_sync(sync),
    .i_two_input(two), .i_stagger_off(flat), .i_str_en(en), .i_ovr(ovr), .o_dim(dim),
    .o_period(per), .o_duty(dut));
  // ****
  // compare and close
  // ****
  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop
  task automatic cmp_word(input logic [23:0] g, input logic [23:0] x);
    checks++;
    if (g !== x) failures++;
    if (g !== x) $display("mismatch %0t word %0d want %0d", $time, g, x);
  endtask : cmp_word
  // circular distance: a free-running phase may wrap the sample window
  task automatic cmp_near(input int g, input int x, input int tol, input int m);
    int d;
    d = ((g - x) % m + m) % m;
    checks++;
    if (d > tol && m - d > tol) failures++;
    if (d > tol && m - d > tol) $display("mismatch %0t count %0d want %0d", $time, g, x);
  endtask : cmp_near
  // settle five periods, then count one period of every string
  task automatic run_case(input logic m2, input logic so, input logic ov, input logic [7:0] e);
    int first[8] = '{default: 0}, wid[8] = '{default: 0}, p, h, n = $countones(e), r = 0, b;
    logic [7:0] prv;
    {two, flat, en, ovr.freq_ovr, ovr.duty_ovr} = {m2, so, e, ov, ov};
    ph = 24'($urandom_range(100, 900));
    p = ov ? int'(ovr.period) : m2 ? int'(ps) : int'(pp);
    h = ov ? int'(ovr.duty) : m2 ? int'(ph) * int'(ps) / int'(pp) : int'(ph);
    repeat (5 * p) @(negedge clk);
    if (!ov) cmp_word(per, m2 ? ps : pp);
    if (!ov && !m2) cmp_word(dut, ph);
    prv = dim;
    for (int t = 1; t <= p; t++)
    begin
      @(negedge clk);
      for (int k = 0; k < 8; k++)
      begin
        wid[k] += int'(dim[k] === 1'b1);
        if (dim[k] === 1'b1 && prv[k] === 1'b0) first[k] = t;
      end
      prv = dim;
    end
    for (int k = 0; k < 8; k++)
    begin
      cmp_near(wid[k], e[k] ? h : 0, int'(m2), p);
      if (e[k])
      begin
        if (r == 0) b = first[k];
        cmp_near(first[k] - b, so ? 0 : r * (p / n), 1, p);
        r++;
      end
    end
    $display("case done mode %0d flat %0d ovr %0d en %h", m2, so, ov, e);
  endtask : run_case
  // hang guard, well above the seven cases
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000) failures++;
    if (cyc == 60000) report_and_stop();
  end
  initial
  begin
    void'($urandom(44));
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    run_case(1'b0, 1'b0, 1'b0, 8'hff);
    run_case(1'b0, 1'b0, 1'b0, 8'h5d);
    run_case(1'b0, 1'b0, 1'b0, 8'($urandom_range(1, 255)));
    run_case(1'b1, 1'b0, 1'b0, 8'hb7);
    run_case(1'b0, 1'b1, 1'b0, 8'hff);
    run_case(1'b0, 1'b0, 1'b0, 8'h00);
    run_case(1'b0, 1'b0, 1'b1, 8'h3c);
    report_and_stop();
  end
endmodule : test_phase_shifted_led_dimming

// *** rtl/psld_core.sv ***
/*
  phase shifted led dimming generator: measures input frequency and duty,
  then replays them on each enabled string with evenly spaced start times.
  assumes pins are already synchronous to i_core_clk.
*/
`timescale 1ns/10ps
// Overview of operation
// - single-input mode: strings copy pwm input frequency and duty.
// - string pulse starts are spread evenly across each period.
// - fault-disabled strings drop out; spacing recomputes over remaining ones.
// - two-input mode: frequency from sync, duty from pwm, stagger from sync.
// - override inputs may set frequency and duty instead of pins.
// - staggering is on by default, derived from enabled count and frequency.
module psld_core #(
  parameter int NSTR = psld_pkg::NSTR
) (
  input wire logic i_core_clk,                 // core clock
  input wire logic i_nrst,                     // async reset, active low
  input wire logic i_pwm,                      // pwm dimming input
  input wire logic i_sync,                     // frequency reference input
  input wire logic i_two_input,                // 1: sync gives frequency
  input wire logic i_stagger_off,              // 1: all strings start together
  input wire logic [NSTR-1:0] i_str_en,        // string enables from fault logic
  input wire psld_pkg::psld_ovr_t i_ovr,       // override controls
  output logic [NSTR-1:0] o_dim,               // string dimming outputs
  output logic [psld_pkg::CW-1:0] o_period,    // measured period in cycles
  output logic [psld_pkg::CW-1:0] o_duty       // measured high time in cycles
);
  localparam int CW = psld_pkg::CW;

  // ****************************************************
  // helpers
  // ****************************************************
  // count enabled strings
  function automatic logic [CW-1:0] pop_cnt(input logic [NSTR-1:0] v);
    logic [CW-1:0] n;
    n = psld_pkg::CNT_ZERO;
    for (int i = 0; i < NSTR; i++)
    begin
      n = n + CW'(v[i]);
    end
    return n;
  endfunction : pop_cnt

  // saturating increment so an idle input never wraps the counter
  function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
    return (v == psld_pkg::CNT_SAT) ? v : v + psld_pkg::CNT_ONE;
  endfunction : sat_inc

  // ****************************************************
  // input edge detection and measurement
  // ****************************************************
  logic pwm_d_r, pwm_d_nxt, sync_d_r, sync_d_nxt;
  logic [CW-1:0] meas_r, meas_nxt, hi_r, hi_nxt;
  logic [CW-1:0] per_r, per_nxt, duty_r, duty_nxt;
  logic [CW-1:0] dmeas_r, dmeas_nxt, dper_r, dper_nxt;
  psld_pkg::psld_state_t st_r, st_nxt;
  logic pwm_rise, sync_rise, ref_rise, ref_lvl;

  assign pwm_rise = i_pwm & ~pwm_d_r;
  assign sync_rise = i_sync & ~sync_d_r;
  // frequency reference selects the stagger base too
  assign ref_rise = i_two_input ? sync_rise : pwm_rise;

  // period from the reference, duty as high time of pwm within its own period
  always_comb
  begin
    pwm_d_nxt = i_pwm;
    sync_d_nxt = i_sync;
    meas_nxt = sat_inc(meas_r);
    per_nxt = per_r;
    hi_nxt = i_pwm ? sat_inc(hi_r) : hi_r;
    duty_nxt = duty_r;
    dmeas_nxt = sat_inc(dmeas_r);
    dper_nxt = dper_r;
    st_nxt = st_r;
    if (ref_rise)
    begin
      meas_nxt = psld_pkg::CNT_ONE;
      per_nxt = meas_r;
    end
    if (pwm_rise)
    begin
      // duty captured on each pwm rising edge, scaled later to the reference period
      hi_nxt = psld_pkg::CNT_ONE;
      duty_nxt = hi_r;
      dper_nxt = dmeas_r;
      dmeas_nxt = psld_pkg::CNT_ONE;
    end
    case (st_r)
      psld_pkg::ST_IDLE: if (ref_rise) st_nxt = psld_pkg::ST_LEARN;
      psld_pkg::ST_LEARN: if (ref_rise) st_nxt = psld_pkg::ST_RUN;
      // a reference that stops for longer than the slowest legal period idles
      psld_pkg::ST_RUN: if (meas_r > CW'(psld_pkg::PMAX_CYC)) st_nxt = psld_pkg::ST_IDLE;
      default: st_nxt = psld_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pwm_d_r <= 1'b0;
      sync_d_r <= 1'b0;
      meas_r <= psld_pkg::CNT_ZERO;
      hi_r <= psld_pkg::CNT_ZERO;
      per_r <= psld_pkg::CNT_ZERO;
      duty_r <= psld_pkg::CNT_ZERO;
      dmeas_r <= psld_pkg::CNT_ZERO;
      dper_r <= psld_pkg::CNT_ZERO;
      st_r <= psld_pkg::ST_IDLE;
    end
    else
    begin
      pwm_d_r <= pwm_d_nxt;
      sync_d_r <= sync_d_nxt;
      meas_r <= meas_nxt;
      hi_r <= hi_nxt;
      per_r <= per_nxt;
      duty_r <= duty_nxt;
      dmeas_r <= dmeas_nxt;
      dper_r <= dper_nxt;
      st_r <= st_nxt;
    end
  end

  // ****************************************************
  // effective period, duty and stagger step
  // ****************************************************
  logic [CW-1:0] eff_per, eff_hi, n_en, step;
  logic [2*CW-1:0] scaled;
  logic static_lvl;

  always_comb
  begin
    // override wins over the pins when selected
    eff_per = i_ovr.freq_ovr ? i_ovr.period : per_r;
    // two-input mode: duty fraction of pwm applied to the sync period
    scaled = (dper_r == psld_pkg::CNT_ZERO) ? {CW'(0), duty_r}
           : ({CW'(0), duty_r} * {CW'(0), eff_per}) / {CW'(0), dper_r};
    eff_hi = i_ovr.duty_ovr ? i_ovr.duty
           : (i_two_input ? scaled[CW-1:0] : duty_r);
    n_en = pop_cnt(i_str_en);
    // one period split over the enabled strings only
    step = (i_stagger_off || n_en == psld_pkg::CNT_ZERO) ? psld_pkg::CNT_ZERO
         : eff_per / n_en;
  end

  // with no edges the input is flat at 0% or 100%: follow its level
  assign ref_lvl = i_pwm;
  assign static_lvl = ref_lvl;

  // ****************************************************
  // shared phase counter and per-string offsets
  // ****************************************************
  logic [NSTR-1:0] dim_r, dim_nxt;
  logic [CW-1:0] phase_r, phase_nxt;
  logic [CW-1:0] ofs [NSTR];
  logic [CW-1:0] t;
  logic [CW-1:0] k;

  // rank each enabled string so disabled ones leave no gap
  always_comb
  begin
    k = psld_pkg::CNT_ZERO;
    for (int i = 0; i < NSTR; i++)
    begin
      ofs[i] = CW'(k * step);
      k = k + CW'(i_str_en[i]);
    end
  end

  always_comb
  begin
    t = psld_pkg::CNT_ZERO;
    phase_nxt = ref_rise ? psld_pkg::CNT_ZERO : sat_inc(phase_r);
    for (int i = 0; i < NSTR; i++)
    begin
      // time since this string's own start, wrapped into one period
      t = (phase_r >= ofs[i]) ? phase_r - ofs[i] : phase_r + eff_per - ofs[i];
      if (!i_str_en[i])
        dim_nxt[i] = 1'b0;
      else if (st_r != psld_pkg::ST_RUN && !i_ovr.freq_ovr)
        dim_nxt[i] = static_lvl;
      else
        dim_nxt[i] = (t < eff_hi);
    end
    // override period free-runs: pin edges must not cut the override period short
    if (i_ovr.freq_ovr)
      phase_nxt = (phase_r + psld_pkg::CNT_ONE >= eff_per) ? psld_pkg::CNT_ZERO
                : phase_r + psld_pkg::CNT_ONE;
  end

  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      dim_r <= '0;
      phase_r <= psld_pkg::CNT_ZERO;
    end
    else
    begin
      dim_r <= dim_nxt;
      phase_r <= phase_nxt;
    end
  end

  assign o_dim = dim_r;
  assign o_period = per_r;
  assign o_duty = duty_r;
endmodule : psld_core

// *** rtl/psld_pkg.sv ***
/*
  constants and carrier types for the phase shifted led dimming block.
  assumes a single 50 mhz core clock and synchronous pin inputs.
*/
package psld_pkg;
  localparam int NSTR = 8;                 // number of led strings
  localparam int CW = 24;                  // period / duty counter width
  localparam int CLK_HZ = 50000000;        // core clock rate
  localparam int FMIN_HZ = 20;             // lowest input dimming frequency
  // longest legal period in cycles, rounded down
  localparam int PMAX_CYC = CLK_HZ / FMIN_HZ;
  localparam logic [CW-1:0] CNT_ZERO = 24'h000000;
  localparam logic [CW-1:0] CNT_ONE = 24'h000001;
  localparam logic [CW-1:0] CNT_SAT = 24'hffffff;

  // software-style overrides presented as plain inputs
  typedef struct packed {
    logic freq_ovr;                        // use override period
    logic duty_ovr;                        // use override duty
    logic [CW-1:0] period;                 // override period in cycles
    logic [CW-1:0] duty;                   // override high time in cycles
  } psld_ovr_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LEARN = 3'b010,
    ST_RUN = 3'b100
  } psld_state_t;
endpackage : psld_pkg
